// ==== rtl/vidr_pkg.sv ====
// Shared types and constants of the serial voltage-ID receiver.
// Assumes one system clock domain plus the serial clock seen at the pins.
package vidr_pkg;

	// ==========================================================
	// Serial frame layout
	localparam int          VIDR_CNT_W      = 4;     // Bit counter width
	localparam logic [3:0]  VIDR_LAST_BIT   = 4'h7;  // Index of eighth bit of a byte
	localparam logic [3:0]  VIDR_CNT_ZERO   = 4'h0;  // Counter start value
	localparam logic [3:0]  VIDR_CNT_ONE    = 4'h1;  // Counter step
	localparam int          VIDR_PAT_HI     = 7;     // Device pattern, top of byte
	localparam int          VIDR_PAT_LO     = 5;     // Device pattern, bottom of byte
	localparam int          VIDR_SEL_CORE1  = 3;     // Second core rail select
	localparam int          VIDR_SEL_CORE0  = 2;     // First or unified core select
	localparam int          VIDR_SEL_NB     = 1;     // Northbridge rail select
	localparam int          VIDR_RW_BIT     = 0;     // Direction bit of address byte
	localparam int          VIDR_PSI_BIT    = 7;     // Power-save hint in data byte
	localparam int          VIDR_CODE_HI    = 6;     // Top of voltage code field
	localparam logic [2:0]  VIDR_DEV_PATTERN = 3'h5; // Arbitrary value, set per system
	localparam logic [7:0]  VIDR_BYTE_ZERO  = 8'h00; // Cleared shift register

	// ==========================================================
	// Update strobe positions
	localparam int VIDR_UPD_CORE0 = 0;
	localparam int VIDR_UPD_CORE1 = 1;
	localparam int VIDR_UPD_NB    = 2;

	// ==========================================================
	// Pin synchroniser lane positions
	localparam int VIDR_SYNC_W    = 7;
	localparam int VIDR_SY_CLK    = 0;
	localparam int VIDR_SY_DATA   = 1;
	localparam int VIDR_SY_BIT    = 2;
	localparam int VIDR_SY_SENSEA = 3;
	localparam int VIDR_SY_SENSEB = 4;
	localparam int VIDR_SY_STRAP  = 5;
	localparam int VIDR_SY_BOOT   = 6;

	// ==========================================================
	// Receiver states, Gray along the normal path
	typedef enum logic [2:0] {
		VIDR_IDLE      = 3'h0,
		VIDR_ADDR      = 3'h1,
		VIDR_ADDR_ACK  = 3'h3,
		VIDR_DATA      = 3'h2,
		VIDR_DATA_ACK  = 3'h6,
		VIDR_WAIT_STOP = 3'h7,
		VIDR_IGNORE    = 3'h5
	} vidr_state_t;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic       powerSaveHintN; // 0: power-save allowed
		logic [6:0] voltageIdCode;  // Voltage code for the rail
	} vidr_rail_t;

	typedef struct packed {
		logic pulseSkip; // Regulator skips pulses
		logic offsetOn;  // Strap offset active
	} vidr_mode_t;

	localparam vidr_rail_t VIDR_RAIL_RST = '{powerSaveHintN: 1'b1, voltageIdCode: 7'h00};
	localparam vidr_mode_t VIDR_MODE_RST = '{pulseSkip: 1'b0, offsetOn: 1'b0};

endpackage : vidr_pkg

// ==== rtl/vidr_sync2.sv ====
// Two-stage synchroniser for a group of independent levels.
// Assumes each lane is a slow level or is qualified elsewhere.
module vidr_sync2 #(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '1 // Reset level of each lane
) (
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         sys_rst,
	// Levels in and out
	input  wire logic [W-1:0] asyncIn,
	output logic      [W-1:0] syncOut
);

	// ==========================================================
	// State
	typedef struct packed {
		logic [W-1:0] meta;   // First stage, read only by second
		logic [W-1:0] stable; // Second stage
	} vidr_sync_st_t;

	vidr_sync_st_t s_q;
	vidr_sync_st_t s_d;

	// Next state
	always_comb begin
		s_d        = s_q;
		s_d.meta   = asyncIn;
		s_d.stable = s_q.meta;
	end

	// Register; each lane resets to its idle level, so no false edge
	// and no spurious strap value follows reset
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s_q <= '{meta: RST_VAL, stable: RST_VAL};
		end else begin
			s_q <= s_d;
		end
	end

	assign syncOut = s_q.stable;

endmodule : vidr_sync2

// ==== rtl/vidr_link_capture.sv ====
// Link-side capture of the serial data bit on each serial clock rise.
// Assumes the master holds data steady while the serial clock is high.
module vidr_link_capture (
	// Link clock
	input  wire logic serialVidClock,
	// Pin in, captured bit out
	input  wire logic serialVidData,
	output logic      linkBit
);

	// ==========================================================
	// State: one data bit, no reset since the link has none
	typedef struct packed {
		logic bitVal; // Last sampled data bit
	} vidr_link_st_t;

	vidr_link_st_t l_q;
	vidr_link_st_t l_d;

	// Sample point is the clock edge itself, best centred on the bit
	always_comb begin
		l_d        = l_q;
		l_d.bitVal = serialVidData;
	end

	// Register
	always_ff @(posedge serialVidClock) begin
		l_q <= l_d;
	end

	assign linkBit = l_q.bitVal;

endmodule : vidr_link_capture

// ==== rtl/vidr_receiver.sv ====
// Receive-only serial voltage-ID slave: frames, address match, ack, decode.
// Assumes a bus master far slower than clk_sys (at most a few hundred kHz)
// so that every serial clock phase spans several system clocks.
module vidr_receiver #(
	parameter logic [2:0] DEV_PATTERN = vidr_pkg::VIDR_DEV_PATTERN // Arbitrary value
) (
	// System clock and reset
	input  wire logic            clk_sys,
	input  wire logic            sys_rst,
	// Serial link pins
	input  wire logic            serialVidClock,
	input  wire logic            serialVidDataIn,
	output logic                 serialVidDataOut,
	output logic                 serialVidDataOeN,
	// Configuration and straps
	input  wire logic            programmingMode,
	input  wire logic            writeBitIsOne,
	input  wire logic            clearRwConflict,
	input  wire logic            combinedModeSenseA,
	input  wire logic            combinedModeSenseB,
	input  wire logic            offsetStrap,
	input  wire logic            bootDone,
	// Status
	output logic                 rwConflict,
	output logic                 lastRwBit,
	output logic                 addressed,
	// Rail outputs
	output vidr_pkg::vidr_rail_t core0Rail,
	output vidr_pkg::vidr_rail_t core1Rail,
	output vidr_pkg::vidr_rail_t northbridgeRail,
	output vidr_pkg::vidr_mode_t core0Mode,
	output vidr_pkg::vidr_mode_t core1Mode,
	output vidr_pkg::vidr_mode_t northbridgeMode,
	output logic                 twoPhase,
	output logic [2:0]           railUpdate
);
	import vidr_pkg::*;

	// ==========================================================
	// Pin synchronisers and link capture
	logic                   linkBit;  // Bit caught on the serial clock
	logic [VIDR_SYNC_W-1:0] pinRaw;   // Lanes before synchronising
	logic [VIDR_SYNC_W-1:0] pinSync;  // Lanes after two flip-flops
	// Bus lanes reset high (idle bus, no false edge); straps reset low
	localparam logic [VIDR_SYNC_W-1:0] SYNC_RST = (VIDR_SYNC_W'(1) << VIDR_SY_CLK) |
		(VIDR_SYNC_W'(1) << VIDR_SY_DATA) | (VIDR_SYNC_W'(1) << VIDR_SY_BIT);

	vidr_link_capture u_link (
		.serialVidClock (serialVidClock),
		.serialVidData  (serialVidDataIn),
		.linkBit        (linkBit)
	);

	// Gather link pins, captured bit, straps and boot level into one synchroniser bank
	always_comb begin
		pinRaw                 = '0;
		pinRaw[VIDR_SY_CLK]    = serialVidClock;
		pinRaw[VIDR_SY_DATA]   = serialVidDataIn;
		pinRaw[VIDR_SY_BIT]    = linkBit;
		pinRaw[VIDR_SY_SENSEA] = combinedModeSenseA;
		pinRaw[VIDR_SY_SENSEB] = combinedModeSenseB;
		pinRaw[VIDR_SY_STRAP]  = offsetStrap;
		pinRaw[VIDR_SY_BOOT]   = bootDone;
	end

	vidr_sync2 #(
		.W       (VIDR_SYNC_W),
		.RST_VAL (SYNC_RST)
	) u_sync (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.asyncIn (pinRaw),
		.syncOut (pinSync)
	);

	// ==========================================================
	// State of the receiver
	typedef struct packed {
		vidr_state_t            state;      // Frame position
		logic [VIDR_CNT_W-1:0]  bitCnt;     // Bits taken in this byte
		logic [7:0]             shiftReg;   // Byte being assembled
		logic [7:0]             addrByte;   // Accepted address byte
		logic [7:0]             dataByte;   // Accepted data byte
		logic                   ackDrive;   // Pulling the data line low
		logic                   ackClocked; // Ack clock pulse has risen
		logic                   svcPrev;    // Synced clock, one cycle back
		logic                   sdaPrev;    // Synced data, one cycle back
		logic                   rwConflict; // Sticky direction mismatch
		logic                   lastRwBit;  // Direction bit last seen
		logic                   addressed;  // Inside an accepted frame
		vidr_rail_t             core0;      // First or unified core rail
		vidr_rail_t             core1;      // Second core rail
		vidr_rail_t             nb;         // Northbridge rail
		vidr_mode_t             m0;         // Regulator mode, core 0
		vidr_mode_t             m1;         // Regulator mode, core 1
		vidr_mode_t             mNb;        // Regulator mode, northbridge
		logic                   twoPhase;   // Combined core phase count
		logic [2:0]             railUpdate; // One-cycle commit strobes
	} vidr_main_st_t;

	vidr_main_st_t r_q;
	vidr_main_st_t r_d;

	// ==========================================================
	// Helpers
	// Regulator mode from the rail's hint, boot state and offset strap
	function automatic vidr_mode_t railMode(input vidr_rail_t rail,
	                                        input logic       booted,
	                                        input logic       strap);
		vidr_mode_t m;
		m.pulseSkip = booted & ~rail.powerSaveHintN;
		m.offsetOn  = strap & rail.powerSaveHintN;
		return m;
	endfunction : railMode

	// Rail value carried by a data byte
	function automatic vidr_rail_t railFromData(input logic [7:0] data);
		vidr_rail_t rail;
		rail.powerSaveHintN = data[VIDR_PSI_BIT];
		rail.voltageIdCode  = data[VIDR_CODE_HI:0];
		return rail;
	endfunction : railFromData

	// ==========================================================
	// Decoded bus events
	logic svcNow;      // Synced serial clock
	logic sdaNow;      // Synced serial data
	logic bitNow;      // Synced captured bit
	logic combined;    // Either sense strap says combined mode
	logic startCond;   // Data fell with clock high
	logic stopCond;    // Data rose with clock high
	logic clkRise;     // Serial clock went high
	logic clkFall;     // Serial clock went low
	logic patternOk;   // Upper address bits match
	logic rwOk;        // Direction bit matches convention
	logic [7:0] fullByte; // Byte including the bit of this rise

	always_comb begin
		svcNow    = pinSync[VIDR_SY_CLK];
		sdaNow    = pinSync[VIDR_SY_DATA];
		bitNow    = pinSync[VIDR_SY_BIT];
		combined  = pinSync[VIDR_SY_SENSEA] | pinSync[VIDR_SY_SENSEB];
		startCond = svcNow & r_q.svcPrev & r_q.sdaPrev & ~sdaNow;
		stopCond  = svcNow & r_q.svcPrev & ~r_q.sdaPrev & sdaNow;
		clkRise   = svcNow & ~r_q.svcPrev;
		clkFall   = ~svcNow & r_q.svcPrev;
		fullByte  = {r_q.shiftReg[6:0], bitNow};
		// Bit 4 of the byte (address bit 3) is left out of the compare
		patternOk = (fullByte[VIDR_PAT_HI:VIDR_PAT_LO] == DEV_PATTERN);
		rwOk      = (fullByte[VIDR_RW_BIT] == writeBitIsOne);
	end

	// ==========================================================
	// Next-state logic
	always_comb begin
		r_d            = r_q;
		r_d.svcPrev    = svcNow;
		r_d.sdaPrev    = sdaNow;
		r_d.railUpdate = 3'h0;

		// Software clear of the conflict flag; a new conflict below wins
		if (clearRwConflict) begin
			r_d.rwConflict = 1'b0;
		end

		// Start restarts reception from any state, stuck or not
		if (startCond) begin
			r_d.state      = VIDR_ADDR;
			r_d.bitCnt     = VIDR_CNT_ZERO;
			r_d.shiftReg   = VIDR_BYTE_ZERO;
			r_d.ackDrive   = 1'b0;
			r_d.ackClocked = 1'b0;
			r_d.addressed  = 1'b0;
		end else if (stopCond) begin
			// Only a full acknowledged command reaches the rails
			if (r_q.state == VIDR_WAIT_STOP) begin
				if (r_q.addrByte[VIDR_SEL_CORE0]) begin
					r_d.core0                      = railFromData(r_q.dataByte);
					r_d.railUpdate[VIDR_UPD_CORE0] = 1'b1;
					// Combined core follows the hint in phase count
					if (combined) begin
						r_d.twoPhase = r_q.dataByte[VIDR_PSI_BIT];
					end
				end
				if (r_q.addrByte[VIDR_SEL_CORE1] && !combined) begin
					r_d.core1                      = railFromData(r_q.dataByte);
					r_d.railUpdate[VIDR_UPD_CORE1] = 1'b1;
				end
				if (r_q.addrByte[VIDR_SEL_NB]) begin
					r_d.nb                      = railFromData(r_q.dataByte);
					r_d.railUpdate[VIDR_UPD_NB] = 1'b1;
				end
			end
			r_d.state      = VIDR_IDLE;
			r_d.ackDrive   = 1'b0;
			r_d.ackClocked = 1'b0;
			r_d.addressed  = 1'b0;
		end else begin
			unique case (r_q.state)
				// Bus free or frame not ours: wait for a start
				VIDR_IDLE, VIDR_IGNORE: begin
				end

				// Address byte, most significant bit first
				VIDR_ADDR: begin
					if (clkRise) begin
						r_d.shiftReg = fullByte;
						r_d.bitCnt   = r_q.bitCnt + VIDR_CNT_ONE;
						if (r_q.bitCnt == VIDR_LAST_BIT) begin
							r_d.bitCnt    = VIDR_CNT_ZERO;
							r_d.addrByte  = fullByte;
							r_d.lastRwBit = fullByte[VIDR_RW_BIT];
							// Read requests are never acked
							if (patternOk && !rwOk) begin
								r_d.rwConflict = 1'b1;
							end
							if (patternOk && rwOk && !programmingMode) begin
								r_d.state     = VIDR_ADDR_ACK;
								r_d.addressed = 1'b1;
							end else begin
								r_d.state = VIDR_IGNORE;
							end
						end
					end
				end

				// Data byte
				VIDR_DATA: begin
					if (clkRise) begin
						r_d.shiftReg = fullByte;
						r_d.bitCnt   = r_q.bitCnt + VIDR_CNT_ONE;
						if (r_q.bitCnt == VIDR_LAST_BIT) begin
							r_d.bitCnt   = VIDR_CNT_ZERO;
							r_d.dataByte = fullByte;
							r_d.state    = VIDR_DATA_ACK;
						end
					end
				end

				// Acknowledge slot: drive low from the fall after the
				// eighth bit until the fall after the ninth clock pulse
				VIDR_ADDR_ACK, VIDR_DATA_ACK: begin
					if (!r_q.ackDrive && !r_q.ackClocked && clkFall) begin
						r_d.ackDrive = 1'b1;
					end else if (r_q.ackDrive && clkRise) begin
						r_d.ackClocked = 1'b1;
					end else if (r_q.ackClocked && clkFall) begin
						// Release only once the clock is low again
						r_d.ackDrive   = 1'b0;
						r_d.ackClocked = 1'b0;
						r_d.shiftReg   = VIDR_BYTE_ZERO;
						r_d.state      = (r_q.state == VIDR_ADDR_ACK) ?
						                 VIDR_DATA : VIDR_WAIT_STOP;
					end
				end

				// One data byte only; a whole extra pulse voids the command.
				// The rise that precedes the stop must not, so act on the fall
				VIDR_WAIT_STOP: begin
					if (clkFall) begin
						r_d.state     = VIDR_IGNORE;
						r_d.addressed = 1'b0;
					end
				end

				default: begin
					r_d.state = VIDR_IDLE;
				end
			endcase
		end

		// Regulator modes track hints, boot state and strap every cycle
		r_d.m0  = railMode(r_q.core0, pinSync[VIDR_SY_BOOT], pinSync[VIDR_SY_STRAP]);
		r_d.m1  = railMode(r_q.core1, pinSync[VIDR_SY_BOOT], pinSync[VIDR_SY_STRAP]);
		r_d.mNb = railMode(r_q.nb, pinSync[VIDR_SY_BOOT], pinSync[VIDR_SY_STRAP]);
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			r_q            <= '0;
			r_q.state      <= VIDR_IDLE;
			r_q.svcPrev    <= 1'b1;
			r_q.sdaPrev    <= 1'b1;
			r_q.core0      <= VIDR_RAIL_RST;
			r_q.core1      <= VIDR_RAIL_RST;
			r_q.nb         <= VIDR_RAIL_RST;
			r_q.m0         <= VIDR_MODE_RST;
			r_q.m1         <= VIDR_MODE_RST;
			r_q.mNb        <= VIDR_MODE_RST;
			r_q.twoPhase   <= 1'b1;
		end else begin
			r_q <= r_d;
		end
	end

	// ==========================================================
	// Outputs
	// Open-drain style: only ever drive low, enable active low
	assign serialVidDataOut = 1'b0;
	assign serialVidDataOeN = ~r_q.ackDrive;
	assign rwConflict       = r_q.rwConflict;
	assign lastRwBit        = r_q.lastRwBit;
	assign addressed        = r_q.addressed;
	assign core0Rail        = r_q.core0;
	assign core1Rail        = r_q.core1;
	assign northbridgeRail  = r_q.nb;
	assign core0Mode        = r_q.m0;
	assign core1Mode        = r_q.m1;
	assign northbridgeMode  = r_q.mNb;
	assign twoPhase         = r_q.twoPhase;
	assign railUpdate       = r_q.railUpdate;

endmodule : vidr_receiver

// ==== verif/vidr_receiver_properties.sv ====
// Concurrent checks on the ports of the voltage-ID receiver.
// Assumes the bench holds programmingMode and the sense pins steady across a frame.
module vidr_receiver_properties (
	// System clock and reset
	input wire logic                 clk_sys,
	input wire logic                 sys_rst,
	// Serial link as seen at the pins
	input wire logic                 serialVidClock,
	input wire logic                 serialVidDataIn,
	input wire logic                 serialVidDataOeN,
	// Configuration
	input wire logic                 programmingMode,
	input wire logic                 combinedModeSenseA,
	input wire logic                 combinedModeSenseB,
	// Status and rails
	input wire logic                 addressed,
	input wire vidr_pkg::vidr_rail_t core0Rail,
	input wire vidr_pkg::vidr_rail_t core1Rail,
	input wire vidr_pkg::vidr_mode_t core0Mode,
	input wire vidr_pkg::vidr_mode_t core1Mode,
	input wire logic                 twoPhase,
	input wire logic           [2:0] railUpdate
);
	timeunit 1ns;
	timeprecision 1ps;
	import vidr_pkg::*;
	// ==========================================================
	// One domain, so clock and disable are given once
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	// Ack pull only moves while the serial clock is low
	chk_ack_fall_low: assert property ($fell(serialVidDataOeN) |-> !serialVidClock)
		else $error("ack began in clock high phase");
	chk_ack_rise_low: assert property ($rose(serialVidDataOeN) |-> !serialVidClock)
		else $error("ack ended in clock high phase");
	chk_ack_needs_addr: assert property (!serialVidDataOeN |-> addressed)
		else $error("ack while not addressed");
	chk_prog_refuses: assert property (programmingMode |-> !$rose(addressed))
		else $error("accepted in programming mode");
	chk_addr_on_high: assert property ($rose(addressed) |-> serialVidClock)
		else $error("address taken away from a clock pulse");
	chk_update_pulse: assert property (|railUpdate |=> railUpdate == 3'h0)
		else $error("update strobe longer than a cycle");
	chk_update_at_stop: assert property (|railUpdate |-> serialVidClock && serialVidDataIn)
		else $error("commit without stop");
	chk_core0_strobed: assert property ($changed(core0Rail) |->
		railUpdate[0] || $past(railUpdate[0]))
		else $error("core0 rail moved without commit");
	chk_core1_strobed: assert property ($changed(core1Rail) |->
		railUpdate[1] || $past(railUpdate[1]))
		else $error("core1 rail moved without commit");
	chk_core1_combined: assert property (railUpdate[1] |->
		!(combinedModeSenseA || combinedModeSenseB))
		else $error("core1 written in combined mode");
	chk_skip_on_hint: assert property (core0Mode.pulseSkip |->
		!$past(core0Rail.powerSaveHintN))
		else $error("pulse skipping with hint high");
	chk_offset_on_hint: assert property (core1Mode.offsetOn |->
		$past(core1Rail.powerSaveHintN))
		else $error("offset on with hint low");
	chk_phase_strobed: assert property ($changed(twoPhase) |->
		railUpdate[0] || $past(railUpdate[0]))
		else $error("phase count moved without commit");
endmodule : vidr_receiver_properties

// ==== verif/vidr_master_model.sv ====
// Behavioural two-wire master that sends voltage-ID commands.
// Assumes the bench resolves the data wire from both drivers with a pull-up.
module vidr_master_model (
	// Resolved data wire
	input  wire logic sdaWire,
	// Lines driven by the master
	output logic      serClk,
	output logic      serDat
);
	timeunit 1ns;
	timeprecision 1ps;
	logic tick = 1'b0; // 64 ns link base, unrelated to clk_sys
	// ==========================================================
	// Link base clock; the serial clock stands still between frames
	always #32 tick = ~tick;
	initial begin
		serClk = 1'b1; // Idle bus
		serDat = 1'b1;
	end
	// One phase; long enough for the synchronised receiver
	task automatic phase();
		repeat (7) @(posedge tick);
	endtask : phase
	// Data changes only while the clock is low
	task automatic put_bit(input logic b, output logic seen);
		serDat = b;
		phase();
		serClk = 1'b1;
		phase();
		seen = sdaWire;
		serClk = 1'b0;
	endtask : put_bit
	// Byte MSB first, then the extra ack pulse with data released
	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			put_bit(b[i], s);
		end
		put_bit(1'b1, s);
		ack = ~s;
	endtask : put_byte
	// Kind 0: address then stop, 1: full command, 2: address, no stop
	task automatic command(input logic [7:0] a, input logic [7:0] d, input int kind,
			output logic ackA, output logic ackD);
		serDat = 1'b1;
		phase();
		serClk = 1'b1;
		phase();
		serDat = 1'b0; // Start, also a repeated start
		phase();
		serClk = 1'b0;
		put_byte(a, ackA);
		ackD = 1'b0;
		if (kind == 1) begin
			put_byte(d, ackD);
		end
		if (kind != 2) begin
			serDat = 1'b0;
			phase();
			serClk = 1'b1;
			phase();
			serDat = 1'b1; // Stop
			phase();
		end
	endtask : command
endmodule : vidr_master_model

// ==== verif/vidr_receiver_tb_top.sv ====
// Self-checking bench: a master model sends commands, rails are compared.
// Assumes the receiver's default device pattern.
module vidr_receiver_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import vidr_pkg::*;
	logic       clk_sys = 1'b0; // 20 MHz system clock
	logic       sys_rst = 1'b1;
	logic       serClk, serDat, dataWire, oeN, dOut;
	logic       prog = 1'b0, wb = 1'b0, clrConf = 1'b0;
	logic       senseA = 1'b0, senseB = 1'b0, strap = 1'b0, boot = 1'b0;
	logic       rwConflict, lastRwBit, addressed, twoPhase;
	logic [2:0] railUpdate;
	vidr_rail_t rail0, rail1, railNb;
	vidr_mode_t mode0, mode1, modeNb;
	logic [7:0] e0 = 8'h80, e1 = 8'h80, eNb = 8'h80; // Expected rails
	logic       eTwo = 1'b1, eConf = 1'b0;
	int         fails = 0, checksDone = 0;
	// ==========================================================
	// Clock, wire resolution and instances
	always #25 clk_sys = ~clk_sys;
	assign dataWire = serDat & (oeN | dOut); // Device pull low wins over the pull-up
	vidr_master_model i_vidr_master_model (.sdaWire(dataWire), .serClk(serClk), .serDat(serDat));
	vidr_receiver i_vidr_receiver (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.serialVidClock(serClk), .serialVidDataIn(dataWire), .serialVidDataOut(dOut),
		.serialVidDataOeN(oeN), .programmingMode(prog), .writeBitIsOne(wb),
		.clearRwConflict(clrConf), .combinedModeSenseA(senseA), .combinedModeSenseB(senseB),
		.offsetStrap(strap), .bootDone(boot), .rwConflict(rwConflict), .lastRwBit(lastRwBit),
		.addressed(addressed), .core0Rail(rail0), .core1Rail(rail1), .northbridgeRail(railNb),
		.core0Mode(mode0), .core1Mode(mode1), .northbridgeMode(modeNb), .twoPhase(twoPhase),
		.railUpdate(railUpdate));
	// ==========================================================
	// Compare and verdict
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checksDone++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask : check
	task automatic test_done();
		if (fails == 0 && checksDone > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : test_done
	// One command, expectations worked out from the address and data bytes
	task automatic run(input logic [7:0] a, input logic [7:0] d, input int kind);
		logic ackA, ackD, eA, comb;
		comb = senseA | senseB;
		eA = (a[7:5] == VIDR_DEV_PATTERN) && (a[0] == wb) && !prog;
		i_vidr_master_model.command(a, d, kind, ackA, ackD);
		repeat (10) @(posedge clk_sys);
		#2;
		if (a[7:5] == VIDR_DEV_PATTERN && a[0] != wb) eConf = 1'b1;
		if (eA && kind == 1) begin
			if (a[2]) e0 = d;
			if (a[3] && !comb) e1 = d;
			if (a[1]) eNb = d;
			if (a[2] && comb) eTwo = d[7];
		end
		check(ackA, eA);
		check(ackD, eA && kind == 1);
		check(rail0, e0);
		check(rail1, e1);
		check(railNb, eNb);
		check(twoPhase, eTwo);
		check({mode0.pulseSkip, mode0.offsetOn}, {boot & ~e0[7], strap & e0[7]});
		check({modeNb.pulseSkip, modeNb.offsetOn}, {boot & ~eNb[7], strap & eNb[7]});
		check(rwConflict, eConf);
		check(addressed, eA && kind == 2);
		if (eA) check(lastRwBit, a[0]);
	endtask : run
	// ==========================================================
	// Main sequence
	initial begin
		repeat (10) @(posedge clk_sys);
		#2;
		sys_rst = 1'b0;
		repeat (4) @(posedge clk_sys);
		#2;
		check(rail0, 8'h80);
		check(oeN, 1'b1);
		run(8'hA4, 8'h15, 1);
		run(8'hA8, 8'h9A, 1);
		run(8'hA2, 8'h7F, 1);
		run(8'hBE, 8'h80, 1); // Bit 4 ignored, all rails at once
		run(8'h64, 8'h33, 1); // Foreign pattern
		run(8'hA5, 8'h11, 1); // Direction refused
		clrConf = 1'b1;
		@(posedge clk_sys);
		#2;
		clrConf = 1'b0;
		eConf = 1'b0;
		@(posedge clk_sys);
		#2;
		check(rwConflict, eConf);
		prog = 1'b1;
		run(8'hA4, 8'h22, 1);
		prog = 1'b0;
		run(8'hA4, 8'h66, 0); // Stop before data
		run(8'hA4, 8'h01, 2); // Repeated start follows
		run(8'hA2, 8'h5C, 1);
		wb = 1'b1;
		run(8'hA5, 8'h44, 1);
		boot = 1'b1;
		strap = 1'b1;
		run(8'hA7, 8'h0A, 1);
		run(8'hA7, 8'h8B, 1);
		senseA = 1'b1;
		run(8'hAF, 8'h03, 1); // Combined: core1 ignored
		senseA = 1'b0;
		senseB = 1'b1;
		run(8'hAD, 8'h90, 1);
		test_done();
	end
	// Watchdog for a hung run
	initial begin
		repeat (60000) @(posedge clk_sys);
		fails++;
		test_done();
	end
endmodule : vidr_receiver_tb_top

bind vidr_receiver vidr_receiver_properties i_vidr_receiver_properties (
	.clk_sys(clk_sys), .sys_rst(sys_rst), .serialVidClock(serialVidClock),
	.serialVidDataIn(serialVidDataIn), .serialVidDataOeN(serialVidDataOeN),
	.programmingMode(programmingMode), .combinedModeSenseA(combinedModeSenseA),
	.combinedModeSenseB(combinedModeSenseB), .addressed(addressed), .core0Rail(core0Rail),
	.core1Rail(core1Rail), .core0Mode(core0Mode), .core1Mode(core1Mode),
	.twoPhase(twoPhase), .railUpdate(railUpdate));
